/* src/fpr_top.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
// Overview of operation
// RULE1: Address register 16 bits, resets 0x0000
// RULE2: Signature register read-only, resets all ones
// RULE3: Volatile protection writes act immediately, keyless
// RULE4: Reset sets volatile protection to all ones
// RULE5: Bit 31 low blocks code reads
// RULE6: Bits 30..0 low write-protect page groups
// RULE7: Software loads keys, enable bit, then 0x06
// RULE8: Mass erase refused without keys and enable
// RULE9: Vector region served by mirrored memory
// RULE10: Any reset mirrors flash at zero
// RULE11: Mirror bit 0 set maps SRAM low
// RULE12: Mirror bit 0 clear restores flash low
// RULE13: Software changes mirror bit outside low region
// RULE14: Reset starts hidden configuration, kernel inaccessible; code blocks kernel reads but accepts writes and erases of kernel pages
// RULE15: Boot pin high: configure, then run vector
// RULE16: SRAM fetch one cycle, data adds one
// RULE17: Flash fetch 32-bit two, 16-bit one; code gives 32-bit one cycle when core_clock_divider is nonzero
// RULE18: Flash data: decode, two, one dead
// RULE19: Flash branch: one decode plus four refill
// RULE20: SRAM branch: one fetch plus two refill
// RULE21: Keyed word same layout, keyed, survives reset
// RULE22: Mass erase clears user space, spares kernel
// RULE23: Signature command fills register, 32778 cycles
// RULE24: Writes to protected page groups refused
module fpr_top #(
  parameter logic [31:0] P_WRITE_CYC = 32'(fpr_pkg::WRITE_CYC),
  parameter logic [31:0] P_ERWR_CYC = 32'(fpr_pkg::ERWR_CYC),
  parameter logic [31:0] P_MASS_CYC = 32'(fpr_pkg::MASS_CYC),
  parameter logic [31:0] P_SIGN_CYC = fpr_pkg::SIGN_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic boot_mode_pin,
  input wire logic [2:0] core_clock_divider,
  input wire logic acc_req,
  input wire logic [31:0] acc_addr,
  input wire fpr_pkg::fpr_kind_type acc_kind,
  input wire logic acc_thumb,
  output logic acc_done,
  output logic acc_sram,
  output logic core_run,
  output logic mirror_sram,
  output logic cmd_busy
);
  import fpr_pkg::*;

  typedef enum logic {S_IDLE, S_BUSY} fpr_state_type;

  // Kernel group has no bit, so grp_ok always passes it as writable
  function automatic logic grp_ok(input logic [31:0] w, input logic [6:0] pg);
    grp_ok = (pg[6:2] == KERNEL_GRP) ? 1'b1 : w[pg[6:2]];
  endfunction : grp_ok

  function automatic logic is_op(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    is_op = (op == a) || (op == b);
  endfunction : is_op

  logic [7:0] mirror_ff, mode_ff, cmd_ff, op_ff;
  logic [15:0] addr_ff, data_ff;
  logic [23:0] sign_ff;
  logic [31:0] vol_ff, keyed_ff, pend_ff, cnt_ff, rdata_ff;
  logic [3:0] stat_ff;
  fpr_state_type state_ff;
  logic [14:0] ptr_ff, end_ff, tgt_ff, rptr_ff;
  logic walk_ff, rvalid_ff;
  logic bm_s1_ff, bm_s2_ff, bm_s3_ff, bm_ff;
  logic run_ff;
  logic [2:0] acc_cnt_ff;
  logic acc_done_ff, acc_sram_ff;

  // Register decode
  wire hit_mirror = reg_addr == OFS_MIRROR;
  wire hit_status = reg_addr == OFS_STATUS;
  wire hit_mode = reg_addr == OFS_MODE;
  wire hit_cmd = reg_addr == OFS_CMD;
  wire hit_data = reg_addr == OFS_DATA;
  wire hit_addr = reg_addr == OFS_ADDR;
  wire hit_sign = reg_addr == OFS_SIGN;
  wire hit_keyed = reg_addr == OFS_KEYED;
  wire hit_vol = reg_addr == OFS_VOL;
  wire busy = state_ff == S_BUSY;
  wire wr_cmd = reg_wr && hit_cmd;
  wire [7:0] new_cmd = reg_wdata[7:0];
  wire start = wr_cmd && !busy;

  // Command qualification
  wire [6:0] page = addr_ff[15:9];
  wire [14:0] word = addr_ff[15:1];
  wire rd_ok = vol_ff[PROT_READ_BIT] && keyed_ff[PROT_READ_BIT] && word <= USER_LAST; // [RULE5] [RULE14]
  wire wr_ok = mode_ff[MODE_KEY_BIT] && grp_ok(vol_ff, page) && grp_ok(keyed_ff, page)
               && page != KEY_PAGE; // [RULE6] [RULE24]
  wire mass_ok = data_ff == KEY_DATA && addr_ff == KEY_ADDR && mode_ff[MODE_KEY_BIT]; // [RULE8]
  wire prot_ok = (&keyed_ff) || ({addr_ff, data_ff} == keyed_ff); // [RULE21]

  logic accept;
  logic [14:0] s_ptr, s_end;
  logic [31:0] s_cnt;
  logic s_walk;

  always_comb begin
    accept = 1'b0;
    s_ptr = word;
    s_end = word;
    s_cnt = SHORT_CYC;
    s_walk = 1'b1;
    case (new_cmd)
      CMD_READ, CMD_VERIFY: begin
        accept = rd_ok;
      end
      CMD_WRITE: begin
        accept = wr_ok;
        s_cnt = P_WRITE_CYC;
      end
      CMD_ERWR, CMD_ERASE: begin
        accept = wr_ok;
        s_ptr = {page, 8'h00};
        s_end = {page, 8'hFF};
        s_cnt = P_ERWR_CYC;
      end
      CMD_MASS: begin
        accept = mass_ok;
        s_ptr = '0;
        s_end = USER_LAST; // [RULE22]
        s_cnt = P_MASS_CYC;
      end
      CMD_SIGN: begin
        accept = 1'b1;
        s_ptr = '0;
        s_end = FLASH_LAST;
        s_cnt = P_SIGN_CYC; // [RULE23]
      end
      CMD_PROT: begin
        accept = prot_ok;
        s_ptr = KEYW_LO;
        s_end = KEYW_HI;
      end
      CMD_PING: begin
        accept = 1'b1;
        s_walk = 1'b0;
      end
      default: begin
        accept = 1'b0;
      end
    endcase
  end

  // Memory walk: one word per cycle, read data one cycle later
  wire walk_last = ptr_ff == end_ff;
  wire wr_op = is_op(op_ff, CMD_WRITE, CMD_ERWR) || is_op(op_ff, CMD_ERASE, CMD_MASS) || op_ff == CMD_PROT;
  wire rd_op = is_op(op_ff, CMD_READ, CMD_VERIFY) || is_op(op_ff, CMD_SIGN, CMD_BOOT);
  wire keep_data = op_ff == CMD_WRITE || (op_ff == CMD_ERWR && ptr_ff == tgt_ff);
  wire mem_we = walk_ff && wr_op;
  wire [15:0] key_half = ptr_ff[0] ? pend_ff[31:16] : pend_ff[15:0];
  wire [15:0] mem_wd = (op_ff == CMD_PROT) ? key_half : keep_data ? data_ff : 16'hFFFF;
  wire [15:0] mem_rd;
  wire fin = busy && cnt_ff == 32'h0 && !walk_ff && !rvalid_ff;
  wire [23:0] sign_next = {sign_ff[22:0], 1'b0} ^ (sign_ff[23] ? SIGN_POLY : 24'h0) ^ {8'h00, mem_rd};

  fpr_mem #(
    .AW(FLASH_AW),
    .DW(16)
  ) u_mem (
    .clk(clk),
    .reset(reset),
    .addr(ptr_ff),
    .we(mem_we),
    .wdata(mem_wd),
    .rdata(mem_rd)
  );

  // Software registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mirror_ff <= RST_MIRROR; // [RULE10]
      mode_ff <= RST_MODE;
      addr_ff <= RST_ADDR; // [RULE1]
      vol_ff <= RST_PROT; // [RULE4]
      pend_ff <= RST_PROT;
    end else if (reg_wr) begin
      if (hit_mirror) begin
        mirror_ff <= {7'h00, reg_wdata[MIR_REMAP_BIT]}; // [RULE11] [RULE12]
      end
      if (hit_mode) begin
        mode_ff <= reg_wdata[7:0] & MODE_MASK;
      end
      if (hit_addr) begin
        addr_ff <= reg_wdata[15:0]; // [RULE1]
      end
      if (hit_vol) begin
        vol_ff <= reg_wdata; // [RULE3]
      end
      if (hit_keyed) begin
        pend_ff <= reg_wdata; // [RULE21]
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_ff <= RST_DATA;
    end else if (rvalid_ff && op_ff == CMD_READ) begin
      data_ff <= mem_rd;
    end else if (reg_wr && hit_data) begin
      data_ff <= reg_wdata[15:0];
    end
  end

  // Command register takes any code written while idle, accepted or refused; 0x07 when done
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_ff <= RST_CMD;
    end else if (start) begin
      cmd_ff <= new_cmd;
    end else if (fin) begin
      cmd_ff <= RST_CMD;
    end
  end

  // Status: done, verify fail, busy (live), refused; set wins over read clear
  wire st_clr = reg_rd && hit_status;
  wire set_done = fin && op_ff != CMD_BOOT;
  wire set_vfail = rvalid_ff && op_ff == CMD_VERIFY && mem_rd != data_ff;
  wire set_ref = wr_cmd && (busy || !accept); // [RULE8] [RULE24]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stat_ff <= 4'h0;
    end else begin
      stat_ff[0] <= set_done || (stat_ff[0] && !st_clr);
      stat_ff[1] <= set_vfail || (stat_ff[1] && !st_clr);
      stat_ff[2] <= 1'b0;
      stat_ff[3] <= set_ref || (stat_ff[3] && !st_clr);
    end
  end

  // Sequencer; reset enters the hidden load of the keyed word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= S_BUSY; // [RULE14]
      op_ff <= CMD_BOOT;
      ptr_ff <= KEYW_LO;
      end_ff <= KEYW_HI;
      tgt_ff <= KEYW_LO;
      walk_ff <= 1'b1;
      cnt_ff <= BOOT_CYC;
    end else if (start && accept) begin
      state_ff <= S_BUSY;
      op_ff <= new_cmd;
      ptr_ff <= s_ptr;
      end_ff <= s_end;
      tgt_ff <= word;
      walk_ff <= s_walk;
      cnt_ff <= s_cnt;
    end else if (busy) begin
      if (walk_ff) begin
        ptr_ff <= ptr_ff + 15'h1;
        walk_ff <= !walk_last;
      end
      if (cnt_ff != 32'h0) begin
        cnt_ff <= cnt_ff - 32'h1;
      end
      if (fin) begin
        state_ff <= S_IDLE;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rptr_ff <= KEYW_LO;
    end else begin
      rvalid_ff <= walk_ff && rd_op;
      rptr_ff <= ptr_ff;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sign_ff <= RST_SIGN; // [RULE2]
    end else if (start && new_cmd == CMD_SIGN) begin
      sign_ff <= RST_SIGN;
    end else if (rvalid_ff && op_ff == CMD_SIGN) begin
      sign_ff <= sign_next; // [RULE23]
    end
  end

  // Keyed word lives in the array, so it outlasts any reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      keyed_ff <= RST_PROT;
    end else if (rvalid_ff && op_ff == CMD_BOOT) begin
      if (rptr_ff[0]) begin
        keyed_ff[31:16] <= mem_rd; // [RULE21]
      end else begin
        keyed_ff[15:0] <= mem_rd;
      end
    end else if (fin && op_ff == CMD_MASS) begin
      keyed_ff <= RST_PROT; // [RULE22]
    end else if (fin && op_ff == CMD_PROT) begin
      keyed_ff <= pend_ff; // [RULE21]
    end
  end

  // Boot pin: three stages, accepted when the last two agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bm_s1_ff <= 1'b0;
      bm_s2_ff <= 1'b0;
      bm_s3_ff <= 1'b0;
      bm_ff <= 1'b0;
    end else begin
      bm_s1_ff <= boot_mode_pin;
      bm_s2_ff <= bm_s1_ff;
      bm_s3_ff <= bm_s2_ff;
      if (bm_s2_ff == bm_s3_ff) begin
        bm_ff <= bm_s2_ff;
      end
    end
  end

  // Core released to the reset vector only in normal boot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_ff <= 1'b0;
    end else if (fin && op_ff == CMD_BOOT && bm_ff) begin
      run_ff <= 1'b1; // [RULE15]
    end
  end

  // Read-back
  wire [31:0] stat_word = {28'h0, stat_ff[3], busy, stat_ff[1:0]};
  wire [31:0] rd_mux = hit_mirror ? {24'h0, mirror_ff} :
                       hit_status ? stat_word :
                       hit_mode ? {24'h0, mode_ff} :
                       hit_cmd ? {24'h0, cmd_ff} :
                       hit_data ? {16'h0, data_ff} :
                       hit_addr ? {16'h0, addr_ff} :
                       hit_sign ? {8'h0, sign_ff} :
                       hit_keyed ? keyed_ff :
                       hit_vol ? vol_ff : 32'h0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Core access cost; slower core clock hides the second half-word
  wire acc_low = acc_addr <= VEC_TOP;
  wire acc_sram_w = acc_low ? mirror_ff[MIR_REMAP_BIT] : acc_addr[31:16] == SRAM_SEG; // [RULE9]
  wire fl_wide = !acc_thumb && core_clock_divider == 3'h0;
  wire [2:0] sram_cost = (acc_kind == FPR_FETCH) ? SRAM_FETCH :
                         (acc_kind == FPR_DATA) ? SRAM_DATA : SRAM_BRANCH; // [RULE16] [RULE20]
  wire [2:0] fl_cost = (acc_kind == FPR_FETCH) ? (fl_wide ? FL_FETCH32 : FL_FETCH16) :
                       (acc_kind == FPR_DATA) ? FL_DATA : FL_BRANCH; // [RULE17] [RULE18] [RULE19]
  wire [2:0] acc_cost = acc_sram_w ? sram_cost : fl_cost;
  wire acc_load = acc_req && acc_cnt_ff == 3'h0 && !acc_done_ff
                  || acc_req && acc_done_ff && acc_cnt_ff == 3'h0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_cnt_ff <= 3'h0;
      acc_sram_ff <= 1'b0;
      acc_done_ff <= 1'b0;
    end else begin
      // Counter holds cycles left after this one, so done lands on the Nth edge
      if (acc_load) begin
        acc_cnt_ff <= acc_cost - 3'h1;
        acc_sram_ff <= acc_sram_w;
      end else if (acc_cnt_ff != 3'h0) begin
        acc_cnt_ff <= acc_cnt_ff - 3'h1;
      end
      acc_done_ff <= (acc_load && acc_cost == 3'h1) || acc_cnt_ff == 3'h1; // [RULE16] [RULE17]
    end
  end

  assign reg_rdata = rdata_ff;
  assign acc_done = acc_done_ff;
  assign acc_sram = acc_sram_ff;
  assign core_run = run_ff;
  assign mirror_sram = mirror_ff[MIR_REMAP_BIT];
  assign cmd_busy = state_ff == S_BUSY;

  addr_write_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    reg_wr && hit_addr |=> addr_ff == $past(reg_wdata[15:0]))
    else $error("address register missed write");
  sign_ro_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    reg_wr && hit_sign && !rvalid_ff && !start |=> $stable(sign_ff))
    else $error("signature changed by write");
  vol_now_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    reg_wr && hit_vol |=> vol_ff == $past(reg_wdata))
    else $error("volatile protection not immediate");
  mass_key_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    wr_cmd && !busy && new_cmd == CMD_MASS && !mass_ok |=> !busy && stat_ff[3])
    else $error("mass erase ran without key");
  wr_prot_a: assert property (@(posedge clk) disable iff (reset) // [RULE24]
    start && is_op(new_cmd, CMD_WRITE, CMD_ERASE) && !wr_ok |=> !mem_we [*2])
    else $error("protected page written");
  rd_prot_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    start && new_cmd == CMD_READ && !keyed_ff[31] |=> !busy)
    else $error("read ran while protected");
  mirror_sel_a: assert property (@(posedge clk) disable iff (reset) // [RULE9]
    acc_req && acc_cnt_ff == 3'h0 && acc_addr == 32'h0 |=> acc_sram == $past(mirror_ff[0]))
    else $error("vector region from wrong memory");
  sram_fetch_a: assert property (@(posedge clk) disable iff (reset) // [RULE16]
    acc_req && acc_cnt_ff == 3'h0 && acc_sram_w && acc_kind == FPR_FETCH |=> acc_done)
    else $error("sram fetch not one cycle");
  fl_fetch_a: assert property (@(posedge clk) disable iff (reset) // [RULE17]
    acc_req && acc_cnt_ff == 3'h0 && !acc_sram_w && acc_kind == FPR_FETCH && fl_wide
    |=> !acc_done ##1 acc_done)
    else $error("flash wide fetch not two cycles");
  fl_data_a: assert property (@(posedge clk) disable iff (reset) // [RULE18]
    acc_req && acc_cnt_ff == 3'h0 && !acc_sram_w && acc_kind == FPR_DATA |=> !acc_done [*3] ##1 acc_done)
    else $error("flash data not four cycles");
  fl_branch_a: assert property (@(posedge clk) disable iff (reset) // [RULE19]
    acc_req && acc_cnt_ff == 3'h0 && !acc_sram_w && acc_kind == FPR_BRANCH |-> ##5 acc_done)
    else $error("flash branch not five cycles");
  sram_branch_a: assert property (@(posedge clk) disable iff (reset) // [RULE20]
    acc_req && acc_cnt_ff == 3'h0 && acc_sram_w && acc_kind == FPR_BRANCH |=> !acc_done [*2] ##1 acc_done)
    else $error("sram branch not three cycles");
endmodule : fpr_top

/* src/fpr_pkg.sv */
package fpr_pkg;
  localparam logic [31:0] OFS_MIRROR = 32'hFFFF0220;
  localparam logic [31:0] OFS_STATUS = 32'hFFFFF800;
  localparam logic [31:0] OFS_MODE = 32'hFFFFF804;
  localparam logic [31:0] OFS_CMD = 32'hFFFFF808;
  localparam logic [31:0] OFS_DATA = 32'hFFFFF80C;
  localparam logic [31:0] OFS_ADDR = 32'hFFFFF810;
  localparam logic [31:0] OFS_SIGN = 32'hFFFFF818;
  localparam logic [31:0] OFS_KEYED = 32'hFFFFF81C;
  localparam logic [31:0] OFS_VOL = 32'hFFFFF820;
  localparam logic [7:0] RST_MIRROR = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_CMD = 8'h07;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [23:0] RST_SIGN = 24'hFFFFFF;
  localparam logic [31:0] RST_PROT = 32'hFFFFFFFF;
  localparam logic [7:0] MODE_MASK = 8'h18;
  localparam int MIR_REMAP_BIT = 0;
  localparam int MODE_KEY_BIT = 3;
  localparam int PROT_READ_BIT = 31;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_ERWR = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE = 8'h05;
  localparam logic [7:0] CMD_MASS = 8'h06;
  localparam logic [7:0] CMD_SIGN = 8'h0B;
  localparam logic [7:0] CMD_PROT = 8'h0C;
  localparam logic [7:0] CMD_PING = 8'h0F;
  localparam logic [7:0] CMD_BOOT = 8'h10;
  localparam logic [15:0] KEY_DATA = 16'h3CFF;
  localparam logic [15:0] KEY_ADDR = 16'hFFC3;
  localparam int FLASH_AW = 15;
  localparam logic [14:0] USER_LAST = 15'h7BFF;
  localparam logic [14:0] FLASH_LAST = 15'h7FFF;
  localparam logic [14:0] KEYW_LO = 15'h7BFE;
  localparam logic [14:0] KEYW_HI = 15'h7BFF;
  localparam logic [6:0] KEY_PAGE = 7'h7B;
  localparam logic [4:0] KERNEL_GRP = 5'h1F;
  localparam logic [23:0] SIGN_POLY = 24'h864CFB;
  localparam logic [31:0] VEC_TOP = 32'h00000020;
  localparam logic [15:0] SRAM_SEG = 16'h0001;
  localparam int CLK_NS = 5;
  localparam int WRITE_US = 50;
  localparam int ERWR_MS = 24;
  localparam int MASS_MS = 2480;
  localparam longint WRITE_CYC = 64'(WRITE_US) * 64'd1000 / 64'(CLK_NS);
  localparam longint ERWR_CYC = 64'(ERWR_MS) * 64'd1000000 / 64'(CLK_NS);
  localparam longint MASS_CYC = 64'(MASS_MS) * 64'd1000000 / 64'(CLK_NS);
  localparam logic [31:0] SIGN_CYC = 32'd32778;
  localparam logic [31:0] SHORT_CYC = 32'd2;
  localparam logic [31:0] BOOT_CYC = 32'd8;
  localparam logic [2:0] SRAM_FETCH = 3'h1;
  localparam logic [2:0] SRAM_DATA = 3'h2;
  localparam logic [2:0] SRAM_BRANCH = 3'h3;
  localparam logic [2:0] FL_FETCH32 = 3'h2;
  localparam logic [2:0] FL_FETCH16 = 3'h1;
  localparam logic [2:0] FL_DATA = 3'h4;
  localparam logic [2:0] FL_BRANCH = 3'h5;
  typedef enum logic [1:0] {FPR_FETCH, FPR_DATA, FPR_BRANCH} fpr_kind_type;
endpackage : fpr_pkg

/* src/fpr_mem.sv */
`timescale 1ns/100ps
module fpr_mem #(
  parameter int AW = 15,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  // Array has no reset: it models nonvolatile cells
  logic [DW-1:0] cell_ff [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (we) begin
      cell_ff[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= cell_ff[addr];
    end
  end

  assign rdata = rdata_ff;
endmodule : fpr_mem

/* verif/fpr_core_model.sv */
`timescale 1ns/100ps
module fpr_core_model (
  input wire logic clk,
  input wire logic acc_done,
  output logic acc_req,
  output logic [31:0] acc_addr,
  output fpr_pkg::fpr_kind_type acc_kind,
  output logic acc_thumb
);
  import fpr_pkg::*;
  initial begin
    acc_req = 1'b0;
    acc_addr = 32'h0;
    acc_kind = FPR_FETCH;
    acc_thumb = 1'b0;
  end
  // One pulse request, then idle long enough for the slowest cost
  task automatic access(input logic [31:0] a, input fpr_kind_type k, input logic t, output int n);
    n = 0;
    @(posedge clk);
    acc_req <= 1'b1;
    acc_addr <= a;
    acc_kind <= k;
    acc_thumb <= t;
    for (int i = 1; i <= 12; i++) begin
      @(posedge clk);
      acc_req <= 1'b0;
      #1;
      if (acc_done === 1'b1 && n == 0) n = i;
    end
  endtask : access
endmodule : fpr_core_model

/* verif/flash_protection_and_remap_test.sv */
`timescale 1ns/100ps
module flash_protection_and_remap_test;
  import fpr_pkg::*;
  logic clk, reset, reg_wr, reg_rd, boot_mode_pin, acc_req, acc_thumb;
  logic acc_done, acc_sram, core_run, mirror_sram, cmd_busy;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, acc_addr;
  logic [2:0] core_clock_divider;
  fpr_kind_type acc_kind;
  int mismatches, checks_done;
  fpr_kind_type kinds [8] = '{FPR_FETCH, FPR_DATA, FPR_BRANCH, FPR_FETCH, FPR_FETCH, FPR_DATA, FPR_BRANCH, FPR_FETCH};
  int exp_cyc [8] = '{1, 2, 3, 2, 1, 4, 5, 1};

  // Short counts so erase and write finish quickly
  fpr_top #(.P_WRITE_CYC(32'd20), .P_ERWR_CYC(32'd300), .P_MASS_CYC(32'd20)) dut (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_mode_pin(boot_mode_pin), .core_clock_divider(core_clock_divider), .acc_req(acc_req),
    .acc_addr(acc_addr), .acc_kind(acc_kind), .acc_thumb(acc_thumb), .acc_done(acc_done),
    .acc_sram(acc_sram), .core_run(core_run), .mirror_sram(mirror_sram), .cmd_busy(cmd_busy));
  fpr_core_model core (.clk(clk), .acc_done(acc_done), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_kind(acc_kind), .acc_thumb(acc_thumb));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Bounded, since the erase walk over user space is long
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (2) @(posedge clk);
    #1;
    while (cmd_busy !== 1'b0 && k < 40000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("cmd_busy", 32'h0, 32'(cmd_busy));
  endtask : wait_idle

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    wait_idle();
    repeat (6) @(posedge clk);
  endtask : do_reset

  task automatic cmd(input logic [7:0] code, output logic [31:0] st);
    wr(OFS_CMD, 32'(code));
    wait_idle();
    rd(OFS_STATUS, st);
    st = st & 32'h9;
  endtask : cmd

  task automatic t_reset_values();
    logic [31:0] v;
    rd(OFS_ADDR, v);
    chk("addr_rst", 32'h0, v);
    rd(OFS_SIGN, v);
    chk("sign_rst", 32'h00FFFFFF, v);
    rd(OFS_VOL, v);
    chk("vol_rst", 32'hFFFFFFFF, v);
    rd(OFS_MIRROR, v);
    chk("mirror_rst", 32'h0, v);
    rd(32'hFFFFF900, v);
    chk("unmapped", 32'h0, v);
    chk("core_run", 32'h1, 32'(core_run));
  endtask : t_reset_values

  task automatic t_regs();
    logic [31:0] v;
    wr(OFS_ADDR, 32'hFFFF1234);
    rd(OFS_ADDR, v);
    chk("addr_rw", 32'h00001234, v);
    wr(OFS_SIGN, 32'h00123456);
    rd(OFS_SIGN, v);
    chk("sign_ro", 32'h00FFFFFF, v);
    wr(OFS_VOL, 32'h7FFFFFFE);
    rd(OFS_VOL, v);
    chk("vol_rw", 32'h7FFFFFFE, v);
  endtask : t_regs

  // Flash starts undefined, so erase comes before protection checks
  task automatic t_mass();
    logic [31:0] st;
    rd(OFS_STATUS, st);
    wr(OFS_DATA, 32'h3CFF);
    wr(OFS_ADDR, 32'hFFC3);
    wr(OFS_MODE, 32'h0);
    cmd(CMD_MASS, st);
    chk("mass_refused", 32'h8, st);
    wr(OFS_MODE, 32'h8);
    cmd(CMD_MASS, st);
    chk("mass_done", 32'h1, st);
    wr(OFS_VOL, 32'h0);
    do_reset();
    rd(OFS_VOL, st);
    chk("vol_cleared", 32'hFFFFFFFF, st);
    cmd(CMD_SIGN, st);
    chk("sign_done", 32'h1, st);
  endtask : t_mass

  task automatic t_prot();
    logic [31:0] st;
    wr(OFS_VOL, 32'h7FFFFFFF);
    wr(OFS_ADDR, 32'h0);
    rd(OFS_STATUS, st);
    cmd(CMD_READ, st);
    chk("read_blocked", 32'h8, st);
    wr(OFS_VOL, 32'hFFFFFFFE);
    cmd(CMD_READ, st);
    chk("read_allowed", 32'h1, st);
    wr(OFS_MODE, 32'h8);
    cmd(CMD_WRITE, st);
    chk("write_blocked", 32'h8, st);
    wr(OFS_VOL, 32'hFFFFFFFF);
    cmd(CMD_WRITE, st);
    chk("write_allowed", 32'h1, st);
  endtask : t_prot

  task automatic t_mirror();
    logic [31:0] v;
    int n;
    wr(OFS_MIRROR, 32'h1);
    rd(OFS_MIRROR, v);
    chk("mirror_rd", 32'h1, v);
    chk("mirror_sram", 32'h1, 32'(mirror_sram));
    core.access(VEC_TOP, FPR_FETCH, 1'b0, n);
    chk("vec_sram", 32'h1, 32'(acc_sram));
    chk("vec_cycles", 32'h1, 32'(n));
    wr(OFS_MIRROR, 32'h0);
    core.access(32'h0, FPR_FETCH, 1'b0, n);
    chk("vec_flash", 32'h0, 32'(acc_sram));
    chk("vec_cycles", 32'h2, 32'(n));
    wr(OFS_MIRROR, 32'h1);
    do_reset();
    chk("mirror_after_rst", 32'h0, 32'(mirror_sram));
  endtask : t_mirror

  task automatic t_timing();
    int n;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      core_clock_divider <= (i == 7) ? 3'h1 : 3'h0;
      core.access((i < 3) ? 32'h00010000 : 32'h00080100, kinds[i], i == 4, n);
      chk("acc_cycles", 32'(exp_cyc[i]), 32'(n));
      chk("acc_mem", 32'(i < 3), 32'(acc_sram));
    end
    core_clock_divider <= 3'h0;
  endtask : t_timing

  task automatic t_boot();
    boot_mode_pin <= 1'b0;
    do_reset();
    chk("run_boot_low", 32'h0, 32'(core_run));
    boot_mode_pin <= 1'b1;
    do_reset();
    chk("run_boot_high", 32'h1, 32'(core_run));
  endtask : t_boot

  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("ERROR watchdog expected finish seen timeout");
    final_report();
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    boot_mode_pin = 1'b1;
    core_clock_divider = 3'h0;
    mismatches = 0;
    checks_done = 0;
    do_reset();
    t_reset_values();
    t_regs();
    t_mass();
    t_prot();
    t_mirror();
    t_timing();
    t_boot();
    final_report();
  end
endmodule : flash_protection_and_remap_test
